/* inc/hsb_regs.svh */
// Timing constants for the hot-swap bus connect controller.
// Assumes a 40 MHz clock; included by the package users by bare name.
`ifndef HSB_REGS_SVH
`define HSB_REGS_SVH
`define HSB_CLK_MHZ 40
// Enable time, initialization hold, in us (typical)
`define HSB_T_EN_US 110
// Bus idle interval, in us (typical, inside 50..200)
`define HSB_T_IDLE_US 105
`define HSB_T_IDLE_MIN_US 50
`define HSB_T_IDLE_MAX_US 200
// STOP to connect delay, in ns (typical)
`define HSB_T_STP_NS 1200
`define HSB_CNT_W 14
`define HSB_T_EN_CYC (`HSB_T_EN_US * `HSB_CLK_MHZ)
`define HSB_T_IDLE_CYC (`HSB_T_IDLE_US * `HSB_CLK_MHZ)
`define HSB_T_STP_CYC ((`HSB_T_STP_NS * `HSB_CLK_MHZ) / 1000)
`define HSB_T_IDLE_MIN_CYC (`HSB_T_IDLE_MIN_US * `HSB_CLK_MHZ)
`define HSB_T_IDLE_MAX_CYC (`HSB_T_IDLE_MAX_US * `HSB_CLK_MHZ)
// Line pair reset value: both lines released high
`define HSB_PAIR_HIGH 2'h3
`endif

/* inc/hsb_pkg.sv */
// Types shared by the hot-swap bus connect controller.
// Assumes nothing beyond a SystemVerilog compiler.
package hsb_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_INIT = 4'h2,
    ST_WAIT = 4'h4,
    ST_CONN = 4'h8
  } hsb_state_type;
  typedef struct packed {
    logic clk_line;
    logic data_line;
  } hsb_pair_type;
endpackage

/* hw/hsb_connect.sv */
// Connection control of a hot-swap two-wire bus buffer.
// Assumes line inputs and enable arrive from pins, asynchronous to clk.
// How it works
// - Ready stays low while enable is low or start-up unfinished.
// - Ready rises only with enable high and sides joined.
// - Enable low separates sides, stops precharge, ready low, low power.
// - After enable rises, no join until both sides finish traffic.
// - Card clock and data must be high before joining.
// - Idle interval before joining lies between 50 and 200 us.
// - Enable falling drops ready at once.
// - Backplane STOP during wait joins about 1.2 us later.
// - Join on full idle interval or on STOP with all lines high.
// - Precharge on during initialization, off when joined.
// - Once joined, a low on one side is driven onto the other.
`timescale 1ns/1ps
`include "hsb_regs.svh"
module hsb_connect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Enable pin
  input wire logic enable,
  // Backplane lines: input, output, output enable (low drives)
  input wire hsb_pkg::hsb_pair_type backplane_in,
  output hsb_pkg::hsb_pair_type backplane_out,
  output hsb_pkg::hsb_pair_type backplane_oe_n,
  // Card lines: input, output, output enable (low drives)
  input wire hsb_pkg::hsb_pair_type card_in,
  output hsb_pkg::hsb_pair_type card_out,
  output hsb_pkg::hsb_pair_type card_oe_n,
  // Status
  output logic ready,
  output logic precharge_on,
  output logic low_power
);
  localparam logic [`HSB_CNT_W-1:0] EN_CYC = `HSB_CNT_W'(`HSB_T_EN_CYC);
  localparam logic [`HSB_CNT_W-1:0] IDLE_CYC =
    `HSB_CNT_W'(`HSB_T_IDLE_CYC);
  localparam logic [`HSB_CNT_W-1:0] STP_CYC = `HSB_CNT_W'(`HSB_T_STP_CYC);
  localparam logic [`HSB_CNT_W-1:0] IDLE_MIN_CYC =
    `HSB_CNT_W'(`HSB_T_IDLE_MIN_CYC);
  localparam logic [`HSB_CNT_W-1:0] IDLE_MAX_CYC =
    `HSB_CNT_W'(`HSB_T_IDLE_MAX_CYC);
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  hsb_pkg::hsb_pair_type bp_s1_q, bp_s2_q, bp_prev_q;
  hsb_pkg::hsb_pair_type cd_s1_q, cd_s2_q;
  logic en_s1_q, en_s2_q;
  hsb_pkg::hsb_state_type state_q, state_d;
  logic [`HSB_CNT_W-1:0] cnt_q, cnt_d;
  logic stop_seen_q, stop_seen_d;
  hsb_pkg::hsb_pair_type bp_drv_q, cd_drv_q;
  hsb_pkg::hsb_pair_type bp_h1_q, bp_h2_q, cd_h1_q, cd_h2_q;
  logic [`HSB_CNT_W-1:0] idle_run_q;

  // Input synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bp_s1_q <= `HSB_PAIR_HIGH;
      bp_s2_q <= `HSB_PAIR_HIGH;
      bp_prev_q <= `HSB_PAIR_HIGH;
      cd_s1_q <= `HSB_PAIR_HIGH;
      cd_s2_q <= `HSB_PAIR_HIGH;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else if (clk_en) begin
      bp_s1_q <= backplane_in;
      bp_s2_q <= bp_s1_q;
      bp_prev_q <= bp_s2_q;
      cd_s1_q <= card_in;
      cd_s2_q <= cd_s1_q;
      en_s1_q <= enable;
      en_s2_q <= en_s1_q;
    end
  end

  // Line observation seen from outside the device's own drive
  wire all_high = (&bp_s2_q) & (&cd_s2_q);
  wire stop_det = bp_s2_q.clk_line & bp_prev_q.clk_line &
    bp_s2_q.data_line & !bp_prev_q.data_line;
  wire connected = (state_q == hsb_pkg::ST_CONN);
  wire join_ok = connected & en_s2_q;
  // Lows the device did not cause; own drive shows two flops late
  wire hsb_pkg::hsb_pair_type bp_ext_low = ~bp_s2_q & ~bp_h2_q;
  wire hsb_pkg::hsb_pair_type cd_ext_low = ~cd_s2_q & ~cd_h2_q;

  // Connection sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    stop_seen_d = stop_seen_q;
    case (state_q)
      hsb_pkg::ST_OFF: begin
        cnt_d = '0;
        stop_seen_d = 1'b0;
        if (en_s2_q) state_d = hsb_pkg::ST_INIT;
      end
      hsb_pkg::ST_INIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= EN_CYC - 1'b1) begin
          state_d = hsb_pkg::ST_WAIT;
          cnt_d = '0;
        end
      end
      hsb_pkg::ST_WAIT: begin
        // Any low line restarts the idle count
        if (!all_high) begin
          cnt_d = '0;
          stop_seen_d = 1'b0;
        end else if (stop_det) begin
          cnt_d = '0;
          stop_seen_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
        if (all_high && stop_seen_q && cnt_q >= STP_CYC - 1'b1)
          state_d = hsb_pkg::ST_CONN;
        if (all_high && cnt_q >= IDLE_CYC - 1'b1)
          state_d = hsb_pkg::ST_CONN;
      end
      hsb_pkg::ST_CONN: cnt_d = '0;
      default: state_d = hsb_pkg::ST_OFF;
    endcase
    if (!en_s2_q) begin
      state_d = hsb_pkg::ST_OFF;
      cnt_d = '0;
      stop_seen_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= hsb_pkg::ST_OFF;
      cnt_q <= '0;
      stop_seen_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stop_seen_q <= stop_seen_d;
    end
  end

  // Cross drive: an outside low on one side is copied to the other
  // Drive history masks our own lows, so the pair cannot latch low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bp_drv_q <= 2'h0;
      cd_drv_q <= 2'h0;
      bp_h1_q <= 2'h0;
      bp_h2_q <= 2'h0;
      cd_h1_q <= 2'h0;
      cd_h2_q <= 2'h0;
    end else if (clk_en) begin
      bp_drv_q <= join_ok ? cd_ext_low : 2'h0;
      cd_drv_q <= join_ok ? bp_ext_low : 2'h0;
      bp_h1_q <= bp_drv_q;
      bp_h2_q <= bp_h1_q;
      cd_h1_q <= cd_drv_q;
      cd_h2_q <= cd_h1_q;
    end
  end

  assign backplane_out = 2'h0;
  assign card_out = 2'h0;
  assign backplane_oe_n = ~bp_drv_q;
  assign card_oe_n = ~cd_drv_q;
  // Raw enable gates ready so it falls without sync delay
  assign ready = connected & enable;
  assign precharge_on = (state_q == hsb_pkg::ST_INIT) |
    (state_q == hsb_pkg::ST_WAIT);
  assign low_power = (state_q == hsb_pkg::ST_OFF);

  // Check helper: wait cycles with every line high, saturating
  wire idle_run_full = (idle_run_q >= IDLE_MAX_CYC);
  wire idle_run_inc = (state_q == hsb_pkg::ST_WAIT) & all_high;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_run_q <= '0;
    end else if (clk_en) begin
      if (!idle_run_inc) idle_run_q <= '0;
      else if (!idle_run_full) idle_run_q <= idle_run_q + 1'b1;
    end
  end

  // Checks
  a_ready_needs_enable: assert property (
    ready |-> enable && connected) else $error("ready without enable");
  a_ready_unjoined: assert property (
    !connected |-> !ready) else $error("ready high while separated");
  a_ready_off_low: assert property (
    !enable |-> !ready) else $error("ready high with enable low");
  a_off_isolated: assert property (
    !connected |-> (&backplane_oe_n) && (&card_oe_n))
    else $error("drive while separated");
  a_off_power: assert property (
    clk_en && !en_s2_q |=> low_power && !precharge_on)
    else $error("precharge or full power with enable low");
  a_join_needs_high: assert property (
    clk_en && $rose(connected) |-> $past(all_high))
    else $error("joined with a low line");
  a_card_low_hold: assert property (
    clk_en && state_q == hsb_pkg::ST_WAIT && !(&cd_s2_q) |=> !connected)
    else $error("joined while card line low");
  a_init_no_join: assert property (
    state_q == hsb_pkg::ST_INIT |=> !connected)
    else $error("joined straight from init");
  a_precharge_init: assert property (
    state_q == hsb_pkg::ST_INIT |-> precharge_on && !low_power)
    else $error("precharge off during init");
  a_precharge_off: assert property (
    connected |-> !precharge_on) else $error("precharge while joined");
  a_ready_rises: assert property (
    $rose(ready) |-> connected) else $error("ready rose unjoined");
  a_enable_drop: assert property (
    clk_en && !en_s2_q |=> !connected) else $error("still joined");
  a_cross_low: assert property (
    clk_en && join_ok && !bp_s2_q.data_line && !bp_h2_q.data_line
    |=> !card_oe_n.data_line) else $error("low not copied to card");
  a_cross_clock: assert property (
    clk_en && join_ok && !cd_s2_q.clk_line && !cd_h2_q.clk_line
    |=> !backplane_oe_n.clk_line) else $error("low not copied to backplane");
  a_wait_low_reset: assert property (
    clk_en && state_q == hsb_pkg::ST_WAIT && !all_high && en_s2_q
    |=> cnt_q == '0) else $error("idle count kept");
  a_idle_min: assert property (
    clk_en && $rose(connected) && !$past(stop_seen_q)
    |-> idle_run_q >= IDLE_MIN_CYC) else $error("idle interval too short");
  a_idle_max: assert property (
    state_q == hsb_pkg::ST_WAIT |-> !idle_run_full)
    else $error("idle interval too long");
  a_stop_join: assert property (
    clk_en && en_s2_q && all_high && state_q == hsb_pkg::ST_WAIT && stop_det
    |-> ##[1:49] (connected || !all_high || !en_s2_q))
    else $error("no join after stop");
endmodule // hsb_connect

/* testbench/hsb_bus_partner.sv */
// Open-drain bus devices on backplane and card, with pull-ups.
// Assumes the controller pulls a line low only while its oe_n is low.
`timescale 1ns/1ps
module hsb_bus_partner (
  // Pull requests from the bench
  input wire hsb_pkg::hsb_pair_type pull_bp,
  input wire hsb_pkg::hsb_pair_type pull_card,
  // Controller drive
  input wire hsb_pkg::hsb_pair_type backplane_out,
  input wire hsb_pkg::hsb_pair_type backplane_oe_n,
  input wire hsb_pkg::hsb_pair_type card_out,
  input wire hsb_pkg::hsb_pair_type card_oe_n,
  // Resolved levels
  output wire hsb_pkg::hsb_pair_type backplane_in,
  output wire hsb_pkg::hsb_pair_type card_in
);
  // A released line goes to the pull-up level
  assign backplane_in = ~pull_bp & (backplane_oe_n | backplane_out);
  assign card_in = ~pull_card & (card_oe_n | card_out);
endmodule // hsb_bus_partner

/* testbench/hsb_connect_tb_top.sv */
// Self-checking bench for the bus connect controller.
// Assumes hsb_connect and hsb_bus_partner are compiled before it.
`timescale 1ns/1ps
`include "hsb_regs.svh"
module hsb_connect_tb_top;
  localparam int JOIN_LO = `HSB_T_EN_CYC + `HSB_T_IDLE_MIN_CYC - 10;
  localparam int JOIN_HI = `HSB_T_EN_CYC + `HSB_T_IDLE_MAX_CYC + 10;
  localparam int STOP_CYC = `HSB_T_STP_CYC;
  logic clk = 0;
  logic rst_n = 0;
  logic enable = 0;
  logic ready, precharge_on, low_power;
  logic [1:0] p;
  hsb_pkg::hsb_pair_type bp_in, bp_out, bp_oe_n, cd_in, cd_out, cd_oe_n;
  hsb_pkg::hsb_pair_type pull_bp = '0;
  hsb_pkg::hsb_pair_type pull_cd = '0;
  int errors = 0;
  int n_tests = 0;
  int n;
  always #12.5 clk = ~clk;
  hsb_connect hsb_connect_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .enable(enable), .backplane_in(bp_in), .backplane_out(bp_out),
    .backplane_oe_n(bp_oe_n), .card_in(cd_in), .card_out(cd_out),
    .card_oe_n(cd_oe_n), .ready(ready), .precharge_on(precharge_on),
    .low_power(low_power));
  hsb_bus_partner hsb_bus_partner_inst (.pull_bp(pull_bp),
    .pull_card(pull_cd), .backplane_out(bp_out), .backplane_oe_n(bp_oe_n),
    .card_out(cd_out), .card_oe_n(cd_oe_n), .backplane_in(bp_in),
    .card_in(cd_in));
  function automatic logic in_range(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cycles(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_ready(int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (ready !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask
  initial begin
    void'($urandom(32'h5B358FDD));
    cycles(5);
    rst_n = 1;
    cycles(1);
    check({ready, low_power}, 2'h1);
    enable = 1;
    cycles(10);
    check({precharge_on, low_power, ready}, 3'h4);
    wait_ready(13000);
    check(in_range(n, JOIN_LO, JOIN_HI), 1'b1);
    check({precharge_on, bp_oe_n, cd_oe_n}, 5'h0F);
    for (int i = 0; i < 6; i++) begin
      p = 2'($urandom_range(1, 3));
      if (i[0])
        pull_bp = p;
      else
        pull_cd = p;
      cycles(5);
      check({bp_in, cd_in}, {~p, ~p});
      pull_bp = '0;
      pull_cd = '0;
      cycles(5);
      check({bp_in, cd_in}, 4'hF);
    end
    pull_cd = 2'h1;
    cycles(5);
    enable = 0;
    #1;
    check(ready, 1'b0);
    cycles(5);
    check({ready, low_power, precharge_on, bp_oe_n, cd_oe_n}, 7'h2F);
    pull_cd = 2'($urandom_range(1, 3));
    enable = 1;
    cycles(12600);
    check({ready, precharge_on}, 2'h1);
    pull_bp = 2'h1;
    pull_cd = '0;
    cycles(3 + $urandom_range(0, 20));
    pull_bp = '0;
    wait_ready(100);
    check(in_range(n, STOP_CYC - 4, STOP_CYC + 12), 1'b1);
    give_verdict();
  end
endmodule // hsb_connect_tb_top
